// ==== hw/ict_consts.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef ICT_CONSTS_SVH
`define ICT_CONSTS_SVH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define ICT_ADDR_MISC_MASK   8'h11
`define ICT_ADDR_LINE_MASK   8'h12
`define ICT_ADDR_IRQ_CTRL    8'h13
`define ICT_ADDR_PERIOD      8'h1A
`define ICT_ADDR_STATUS      8'h20
`define ICT_ADDR_PENDING     8'h21

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define ICT_RST_MISC_MASK    8'h00
`define ICT_RST_LINE_MASK    8'h00
`define ICT_RST_IRQ_CTRL     8'h00
`define ICT_RST_PERIOD       8'h00
`define ICT_RST_RDATA        8'h00
`define ICT_IRQ_PIN_RST      1'b1

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define ICT_LINE_MASK_BIT    0
`define ICT_MISC_TIMER_BIT   1
`define ICT_ST_LINE          0
`define ICT_ST_TIMER         1
`define ICT_ST_WDOG          2
`define ICT_ST_W             3

// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define ICT_CLK_MHZ          100
`define ICT_TMR_BASE_US      250
`define ICT_WD_BASE_MS       2
`define ICT_TMR_BASE_CYCLES  (`ICT_TMR_BASE_US * `ICT_CLK_MHZ)
`define ICT_WD_BASE_CYCLES   (`ICT_WD_BASE_MS * 1000 * `ICT_CLK_MHZ)

`endif

// ==== hw/ict_irq_control.sv ====
// interrupt pin control, status flags and timer/watchdog periods
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "ict_consts.svh"

module ict_irq_control
#(
   parameter int FIFO_NUM        = 8,
   parameter int TMR_BASE_CYCLES = `ICT_TMR_BASE_CYCLES,
   parameter int WD_BASE_CYCLES  = `ICT_WD_BASE_CYCLES
)
(
   // clock and reset
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst_n,
   // reset groups 0 and 3, synchronous
   input  wire logic                 i_rst_grp0,
   input  wire logic                 i_rst_grp3,
   // register bus
   input  wire ict_pkg::ict_bus_req_s i_bus,
   output logic [7:0]                o_rdata,
   // interrupt sources
   input  wire logic                 i_line_state_change,
   input  wire logic [FIFO_NUM-1:0]  i_fifo_irq_pending,
   input  wire logic [FIFO_NUM-1:0]  i_per_fifo_irq_mask,
   // outputs
   output logic                      o_irq,
   output logic                      o_timer_event,
   output logic                      o_watchdog_event
);
   import ict_pkg::*;

   if (FIFO_NUM < 1 || FIFO_NUM > 32)
   begin : g_chk_fifo
      $error("fifo count must lie between 1 and 32");
   end

   // --------------------------------------------------------------
   // declarations
   // --------------------------------------------------------------
   logic [7:0]          misc_irq_mask_reg_r;
   logic [7:0]          line_state_irq_mask_reg_r;
   ict_ctrl_s           ctrl_r;
   ict_period_s         timer_watchdog_period_reg_r;
   logic [7:0]          rdata_r;
   logic                irq_pin_r;
   logic [`ICT_ST_W-1:0] stat_r;
   logic [`ICT_ST_W-1:0] stat_set;
   logic [`ICT_ST_W-1:0] stat_clr;
   logic [`ICT_ST_W-1:0] stat_msk;
   logic                wr_misc;
   logic                wr_line;
   logic                wr_ctrl;
   logic                wr_period;
   logic                wr_status;
   logic                tmr_clr;
   logic                tmr_evt;
   logic                wd_evt;
   logic                own_req;
   logic                fifo_req;
   logic                irq_act;

   // --------------------------------------------------------------
   // write decode
   // --------------------------------------------------------------
   assign wr_misc   = i_bus.wr && (i_bus.addr == `ICT_ADDR_MISC_MASK);
   assign wr_line   = i_bus.wr && (i_bus.addr == `ICT_ADDR_LINE_MASK);
   assign wr_ctrl   = i_bus.wr && (i_bus.addr == `ICT_ADDR_IRQ_CTRL);
   assign wr_period = i_bus.wr && (i_bus.addr == `ICT_ADDR_PERIOD);
   assign wr_status = i_bus.wr && (i_bus.addr == `ICT_ADDR_STATUS);

   // --------------------------------------------------------------
   // mask and control registers
   // --------------------------------------------------------------
   // reserved bits are stored as written; nothing reads them
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         misc_irq_mask_reg_r <= `ICT_RST_MISC_MASK;
      end
      else if (wr_misc)
      begin
         misc_irq_mask_reg_r <= i_bus.wdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         line_state_irq_mask_reg_r <= `ICT_RST_LINE_MASK;
      end
      else if (i_rst_grp0 || i_rst_grp3)
      begin
         line_state_irq_mask_reg_r <= `ICT_RST_LINE_MASK;
      end
      else if (wr_line)
      begin
         line_state_irq_mask_reg_r <= i_bus.wdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ctrl_r <= ict_ctrl_s'(`ICT_RST_IRQ_CTRL);
      end
      else if (i_rst_grp0)
      begin
         ctrl_r <= ict_ctrl_s'(`ICT_RST_IRQ_CTRL);
      end
      else if (wr_ctrl)
      begin
         ctrl_r <= ict_ctrl_s'(i_bus.wdata);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         timer_watchdog_period_reg_r <= ict_period_s'(`ICT_RST_PERIOD);
      end
      else if (i_rst_grp0)
      begin
         timer_watchdog_period_reg_r <= ict_period_s'(`ICT_RST_PERIOD);
      end
      else if (wr_period)
      begin
         timer_watchdog_period_reg_r <= ict_period_s'(i_bus.wdata);
      end
   end

   // --------------------------------------------------------------
   // timer and watchdog
   // --------------------------------------------------------------
   // a new period takes effect from a clean start, not mid-count
   assign tmr_clr = i_rst_grp0 || wr_period;

   ict_period_timer
   #(
      .BASE_CYCLES (TMR_BASE_CYCLES),
      .CODE_W      (4)
   )
   u_timer
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_clr      (tmr_clr),
      .i_code     (timer_watchdog_period_reg_r.timer_interval_code),
      .o_event    (tmr_evt)
   );

   ict_period_timer
   #(
      .BASE_CYCLES (WD_BASE_CYCLES),
      .CODE_W      (4)
   )
   u_wdog
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_clr      (tmr_clr),
      .i_code     (timer_watchdog_period_reg_r.watchdog_interval_code),
      .o_event    (wd_evt)
   );

   assign o_timer_event    = tmr_evt;
   assign o_watchdog_event = wd_evt;

   // --------------------------------------------------------------
   // sticky status, write one to clear
   // --------------------------------------------------------------
   // flags set regardless of masks, so software can poll them
   assign stat_set = {wd_evt, tmr_evt, i_line_state_change};
   assign stat_clr = wr_status ? i_bus.wdata[`ICT_ST_W-1:0] : '0;

   for (genvar gi = 0; gi < `ICT_ST_W; gi++)
   begin : g_stat
      ict_sticky_bit u_bit
      (
         .i_core_clk (i_core_clk),
         .i_rst_n    (i_rst_n),
         .i_set      (stat_set[gi]),
         .i_clr      (stat_clr[gi]),
         .o_q        (stat_r[gi])
      );
   end

   // --------------------------------------------------------------
   // interrupt pin
   // --------------------------------------------------------------
   // watchdog has no mask here and never reaches the pin
   assign stat_msk = {1'b0,
                      misc_irq_mask_reg_r[`ICT_MISC_TIMER_BIT],
                      line_state_irq_mask_reg_r[`ICT_LINE_MASK_BIT]};
   assign own_req  = |(stat_r & stat_msk);
   assign fifo_req = ctrl_r.fifo_irq_enable &&
                     |(i_fifo_irq_pending & i_per_fifo_irq_mask);
   assign irq_act  = ctrl_r.global_irq_pin_enable &&
                     (own_req || fifo_req);

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         irq_pin_r <= `ICT_IRQ_PIN_RST;
      end
      else
      begin
         irq_pin_r <= irq_act ? ctrl_r.irq_pin_polarity
                              : !ctrl_r.irq_pin_polarity;
      end
   end

   assign o_irq = irq_pin_r;

   // --------------------------------------------------------------
   // read port
   // --------------------------------------------------------------
   // mask, control and period registers are write only
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rdata_r <= `ICT_RST_RDATA;
      end
      else if (i_bus.rd)
      begin
         case (i_bus.addr)
            `ICT_ADDR_STATUS:  rdata_r <= 8'(stat_r);
            `ICT_ADDR_PENDING: rdata_r <= 8'({fifo_req, stat_r & stat_msk});
            default:           rdata_r <= `ICT_RST_RDATA;
         endcase
      end
      else
      begin
         rdata_r <= `ICT_RST_RDATA;
      end
   end

   assign o_rdata = rdata_r;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   logic [39:0] tmr_gap_r;
   logic [39:0] wd_gap_r;
   logic        tmr_seen_r;
   logic        wd_seen_r;

   // cycles since the last event, restarted with the timers
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tmr_gap_r  <= '0;
         wd_gap_r   <= '0;
         tmr_seen_r <= 1'b0;
         wd_seen_r  <= 1'b0;
      end
      else
      begin
         tmr_gap_r  <= (tmr_clr || tmr_evt) ? '0 : tmr_gap_r + 1'b1;
         wd_gap_r   <= (tmr_clr || wd_evt) ? '0 : wd_gap_r + 1'b1;
         tmr_seen_r <= !tmr_clr && (tmr_seen_r || tmr_evt);
         wd_seen_r  <= !tmr_clr && (wd_seen_r || wd_evt);
      end
   end

   property p_line_routed;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ctrl_r.global_irq_pin_enable && stat_r[`ICT_ST_LINE] &&
       line_state_irq_mask_reg_r[`ICT_LINE_MASK_BIT])
      |=> (irq_pin_r == $past(ctrl_r.irq_pin_polarity));
   endproperty
   a_line_routed: assert property (p_line_routed)
      else $error("unmasked line change did not assert pin");

   property p_masked_flag;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_line_state_change && !line_state_irq_mask_reg_r[0])
      |=> stat_r[`ICT_ST_LINE] ##1
          (rdata_r[0] || !($past(i_bus.rd) &&
                           $past(i_bus.addr) == `ICT_ADDR_STATUS));
   endproperty
   a_masked_flag: assert property (p_masked_flag)
      else $error("masked line change flag not kept");

   property p_grp3_clear;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_rst_grp3 |=> (line_state_irq_mask_reg_r == `ICT_RST_LINE_MASK);
   endproperty
   a_grp3_clear: assert property (p_grp3_clear)
      else $error("line mask not cleared by reset group 3");

   property p_fifo_group_off;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!ctrl_r.fifo_irq_enable && !own_req)
      |=> (irq_pin_r != $past(ctrl_r.irq_pin_polarity));
   endproperty
   a_fifo_group_off: assert property (p_fifo_group_off)
      else $error("fifo interrupt passed while group disabled");

   property p_fifo_on;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ctrl_r.global_irq_pin_enable && ctrl_r.fifo_irq_enable &&
       |(i_fifo_irq_pending & i_per_fifo_irq_mask))
      |=> (irq_pin_r == $past(ctrl_r.irq_pin_polarity));
   endproperty
   a_fifo_on: assert property (p_fifo_on)
      else $error("enabled fifo interrupt missing on pin");

   property p_global_off;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !ctrl_r.global_irq_pin_enable
      |=> (irq_pin_r != $past(ctrl_r.irq_pin_polarity));
   endproperty
   a_global_off: assert property (p_global_off)
      else $error("pin asserted while globally disabled");

   property p_high_active;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (ctrl_r.irq_pin_polarity && irq_act) |=> irq_pin_r;
   endproperty
   a_high_active: assert property (p_high_active)
      else $error("active high pin not driven high");

   property p_timer_gap;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (tmr_evt && tmr_seen_r) |-> (tmr_gap_r == (40'(TMR_BASE_CYCLES)
         << timer_watchdog_period_reg_r.timer_interval_code) - 40'd1);
   endproperty
   a_timer_gap: assert property (p_timer_gap)
      else $error("timer event spacing wrong");

   property p_wdog_gap;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wd_evt && wd_seen_r) |-> (wd_gap_r == (40'(WD_BASE_CYCLES)
         << timer_watchdog_period_reg_r.watchdog_interval_code) - 40'd1);
   endproperty
   a_wdog_gap: assert property (p_wdog_gap)
      else $error("watchdog event spacing wrong");

   property p_timer_masked;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (tmr_evt && !wr_status) |=> stat_r[`ICT_ST_TIMER];
   endproperty
   a_timer_masked: assert property (p_timer_masked)
      else $error("timer status flag not set");

   property p_idle;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!own_req && !fifo_req)
      |=> (irq_pin_r == !$past(ctrl_r.irq_pin_polarity));
   endproperty
   a_idle: assert property (p_idle)
      else $error("pin active with nothing pending");

endmodule

// ==== hw/ict_period_timer.sv ====
// event timer with period base_cycles times two to the code
`timescale 1ns/1ns

module ict_period_timer
#(
   parameter int BASE_CYCLES = 25000,
   parameter int CODE_W      = 4
)
(
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   // control
   input  wire logic              i_clr,
   input  wire logic [CODE_W-1:0] i_code,
   // one-cycle event
   output logic                   o_event
);

   localparam int PRE_W  = $clog2(BASE_CYCLES);
   localparam int TICK_W = 1 << CODE_W;

   logic [PRE_W-1:0]  pre_r;
   logic [TICK_W-1:0] tick_r;
   logic [TICK_W-1:0] last_tick;
   logic              base_tick;

   if (BASE_CYCLES < 2)
   begin : g_chk
      $error("timer base must be at least two cycles");
   end

   assign base_tick = (pre_r == PRE_W'(BASE_CYCLES - 1));
   assign last_tick = ~({TICK_W{1'b1}} << i_code);

   // --------------------------------------------------------------
   // base prescaler
   // --------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pre_r <= '0;
      end
      else if (i_clr || base_tick)
      begin
         pre_r <= '0;
      end
      else
      begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // --------------------------------------------------------------
   // power of two tick count
   // --------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tick_r <= '0;
      end
      else if (i_clr)
      begin
         tick_r <= '0;
      end
      else if (base_tick)
      begin
         tick_r <= (tick_r >= last_tick) ? '0 : tick_r + 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_event <= 1'b0;
      end
      else
      begin
         o_event <= !i_clr && base_tick && (tick_r >= last_tick);
      end
   end

endmodule

// ==== hw/ict_pkg.sv ====
// types shared by the interrupt control block
package ict_pkg;

   // -----------------------------------------------------------------
   // register bus request
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ict_bus_req_s;

   // -----------------------------------------------------------------
   // interrupt control register layout
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] rsvd_hi;
      logic       irq_pin_polarity;
      logic       global_irq_pin_enable;
      logic [1:0] rsvd_lo;
      logic       fifo_irq_enable;
   } ict_ctrl_s;

   // -----------------------------------------------------------------
   // timer and watchdog period register layout
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] watchdog_interval_code;
      logic [3:0] timer_interval_code;
   } ict_period_s;

endpackage

// ==== hw/ict_sticky_bit.sv ====
// one sticky status bit, set by hardware, cleared by writing one
`timescale 1ns/1ns

module ict_sticky_bit
(
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // set and clear
   input  wire logic i_set,
   input  wire logic i_clr,
   // state
   output logic      o_q
);

   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_q <= 1'b0;
      end
      else
      begin
         o_q <= i_set | (o_q & ~i_clr);
      end
   end

endmodule

// ==== tb/ict_host_model.sv ====
// host side model of the interrupt input that watches the pin
`timescale 1ns/1ns

module ict_host_model
(
   // pin and host setting
   input  wire logic i_irq,
   input  wire logic i_active_high,
   // host view
   output logic      o_irq_req
);
   // host decodes the pin at the level it was told to expect
   assign o_irq_req = i_active_high ? i_irq : ~i_irq;
endmodule

// ==== tb/ict_irq_control_tb_top.sv ====
// self-checking bench for the interrupt control block
`timescale 1ns/1ns
`include "ict_consts.svh"

module ict_irq_control_tb_top;
   import ict_pkg::*;

   localparam int TB = 4;
   localparam int WB = 8;

   logic                 i_core_clk;
   logic                 i_rst_n;
   logic                 i_rst_grp0;
   logic                 i_rst_grp3;
   ict_bus_req_s         i_bus;
   logic [7:0]           o_rdata;
   logic                 i_line_state_change;
   logic [7:0]           i_fifo_irq_pending;
   logic [7:0]           i_per_fifo_irq_mask;
   logic                 o_irq;
   logic                 o_timer_event;
   logic                 o_watchdog_event;
   logic                 pol;
   logic                 host_req;
   logic                 en;
   logic                 rd_pend;
   logic [7:0]           exp_q[$];
   int                   n_fail;
   int                   num_checks;
   int                   cyc;

   ict_irq_control #(.FIFO_NUM(8), .TMR_BASE_CYCLES(TB),
                     .WD_BASE_CYCLES(WB)) u_ict_irq_control
   (
      .i_core_clk          (i_core_clk),
      .i_rst_n             (i_rst_n),
      .i_rst_grp0          (i_rst_grp0),
      .i_rst_grp3          (i_rst_grp3),
      .i_bus               (i_bus),
      .o_rdata             (o_rdata),
      .i_line_state_change (i_line_state_change),
      .i_fifo_irq_pending  (i_fifo_irq_pending),
      .i_per_fifo_irq_mask (i_per_fifo_irq_mask),
      .o_irq               (o_irq),
      .o_timer_event       (o_timer_event),
      .o_watchdog_event    (o_watchdog_event)
   );

   ict_host_model u_ict_host_model
   (
      .i_irq         (o_irq),
      .i_active_high (pol),
      .o_irq_req     (host_req)
   );

   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // -----------------------------------------------------------------
   // compare, bus and closing tasks
   // -----------------------------------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_core_clk);
      i_bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge i_core_clk);
      i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_core_clk);
      i_bus.rd <= 1'b0;
   endtask

   // pin settles two cycles after its cause; two spare cycles
   task automatic pin(input logic e);
      repeat (3) @(posedge i_core_clk);
      @(negedge i_core_clk);
      cmp8({7'h00, host_req}, {7'h00, e});
   endtask

   // k: 0 line change, 1 reset group 0, 3 reset group 3
   task automatic pulse(input int k);
      @(posedge i_core_clk);
      i_line_state_change <= (k == 0);
      i_rst_grp0          <= (k == 1);
      i_rst_grp3          <= (k == 3);
      @(posedge i_core_clk);
      i_line_state_change <= 1'b0;
      i_rst_grp0          <= 1'b0;
      i_rst_grp3          <= 1'b0;
   endtask

   // cycles between two events of the chosen timer
   task automatic gap(input logic w, input int e);
      int n;
      n = 0;
      @(negedge i_core_clk);
      while ((w ? o_watchdog_event : o_timer_event) !== 1'b1 && n < 4000)
      begin
         @(negedge i_core_clk);
         n++;
      end
      n = 0;
      do
      begin
         @(negedge i_core_clk);
         n++;
      end
      while ((w ? o_watchdog_event : o_timer_event) !== 1'b1 && n < 4000);
      cmp8(n[7:0], e[7:0]);
   endtask

   // -----------------------------------------------------------------
   // read data watcher and hang guard
   // -----------------------------------------------------------------
   always @(negedge i_core_clk)
   begin
      if (rd_pend)
         cmp8(o_rdata, exp_q.pop_front());
      rd_pend = i_bus.rd;
   end

   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_of_test();
      end
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial
   begin
      i_rst_n = 1'b0;
      i_rst_grp0 = 1'b0;
      i_rst_grp3 = 1'b0;
      i_bus = '0;
      i_line_state_change = 1'b0;
      i_fifo_irq_pending = 8'h00;
      i_per_fifo_irq_mask = 8'h00;
      pol = 1'b0;
      rd_pend = 1'b0;
      n_fail = 0;
      num_checks = 0;
      cyc = 0;
      void'($urandom(32'h24e0));
      repeat (20) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      pin(1'b0);
      // slowest periods keep timer flags quiet for the early tests
      wr(`ICT_ADDR_PERIOD, 8'hFF);
      wr(`ICT_ADDR_STATUS, 8'h07);
      rd(`ICT_ADDR_STATUS, 8'h00);
      rd(`ICT_ADDR_LINE_MASK, 8'h00);
      rd(8'h55, 8'h00);
      wr(`ICT_ADDR_IRQ_CTRL, 8'h18);
      pol <= 1'b1;
      pin(1'b0);
      pulse(0);
      pin(1'b0);
      rd(`ICT_ADDR_STATUS, 8'h01);
      wr(`ICT_ADDR_LINE_MASK, 8'h01);
      pin(1'b1);
      rd(`ICT_ADDR_PENDING, 8'h01);
      wr(`ICT_ADDR_IRQ_CTRL, 8'h08);
      pol <= 1'b0;
      pin(1'b1);
      wr(`ICT_ADDR_IRQ_CTRL, 8'h00);
      pin(1'b0);
      wr(`ICT_ADDR_IRQ_CTRL, 8'h18);
      pol <= 1'b1;
      pin(1'b1);
      pulse(3);
      pin(1'b0);
      wr(`ICT_ADDR_STATUS, 8'h01);
      rd(`ICT_ADDR_STATUS, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         en = (i == 1) ? 1'b0 : 1'($urandom());
         i_fifo_irq_pending <= (i < 2) ? 8'hFF : 8'($urandom());
         i_per_fifo_irq_mask <= (i == 0) ? 8'h00 : 8'($urandom());
         wr(`ICT_ADDR_IRQ_CTRL, {7'h0C, en});
         pin(en & |(i_fifo_irq_pending & i_per_fifo_irq_mask));
      end
      i_fifo_irq_pending <= 8'h00;
      wr(`ICT_ADDR_MISC_MASK, 8'h02);
      wr(`ICT_ADDR_PERIOD, 8'h00);
      // first timer event lands a base period after the restart
      repeat (6) @(posedge i_core_clk);
      pin(1'b1);
      wr(`ICT_ADDR_MISC_MASK, 8'h00);
      pin(1'b0);
      rd(`ICT_ADDR_STATUS, 8'h06);
      for (int c = 0; c < 5; c++)
      begin
         wr(`ICT_ADDR_PERIOD, {4'(c), 4'(c)});
         gap(1'b0, TB << c);
         gap(1'b1, WB << c);
      end
      wr(`ICT_ADDR_LINE_MASK, 8'h01);
      pulse(1);
      pol <= 1'b0;
      pin(1'b0);
      wr(`ICT_ADDR_IRQ_CTRL, 8'h18);
      pol <= 1'b1;
      pulse(0);
      pin(1'b0);
      gap(1'b0, TB);
      end_of_test();
   end
endmodule
